/* File: sdram_timing_pkg.sv */
package sdram_timing_pkg;

	// Array geometry.
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int DQ_W = 16;
	localparam int BANKS = 4;
	localparam int ARR_ADDR_W = BANK_W + ROW_W + COL_W;
	localparam int WR_WORD_W = ARR_ADDR_W + DQ_W;
	localparam int WR_FIFO_DEPTH = 4;

	// Command codes as {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;

	// Address bit that selects all banks on a precharge.
	localparam int AP_BIT = 10;

	// Mode word fields and codes.
	localparam int BL_LSB = 0;
	localparam int BL_MSB = 2;
	localparam int RLS_LSB = 4;
	localparam int RLS_MSB = 6;
	localparam logic [2:0] RLS_THREE = 3'h3;
	localparam logic [2:0] BL_CODE_RESET = 3'h0;
	localparam logic [2:0] BL_CODE_FULL = 3'h7;

	// Burst lengths, counted in beats.
	localparam int BURST_W = 9;
	localparam logic [BURST_W-1:0] BURST_ONE = 9'h001;
	localparam logic [BURST_W-1:0] BURST_FULL = 9'h100;

	// Latencies in cycles.
	localparam int CLOCK_ENABLE_LATENCY = 1;
	localparam int READ_MASK_FLOAT_LATENCY = 2;
	localparam int WRITE_MASK_LATENCY = 0;

	// Burst sequencing state.
	typedef enum logic [1:0] {
		BURST_IDLE,
		BURST_READ,
		BURST_WRITE
	} burst_state_type;

endpackage

/* File: stream_if.sv */
`timescale 1ns/1ps
// Valid/ready word stream into and out of the write buffer.
interface stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface // stream_if

/* File: stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Filling and draining sides.
	stream_if.sink in_s,
	stream_if.source out_s
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic full_r;
	logic empty_r;
	logic push;
	logic pop;

	// Full and empty are flops so that ready and valid leave cleanly.
	assign push = in_s.valid && !full_r;
	assign pop = out_s.ready && !empty_r;
	assign in_s.ready = !full_r;
	assign out_s.valid = !empty_r;
	assign out_s.data = mem_r[rd_ptr_r];

	// Storage needs no reset; empty_r hides stale words.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_s.data;
		end
	end

	// Pointers wrap at the last slot, so any depth works.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
			end
		end
	end

	// Occupancy after this edge.
	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	// Occupancy and flags.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= '0;
			full_r <= 1'b0;
			empty_r <= 1'b1;
		end else begin
			count_r <= count_nxt;
			full_r <= (count_nxt == CNT_FULL);
			empty_r <= (count_nxt == '0);
		end
	end
endmodule // stream_fifo

/* File: sdram_command_timing.sv */
`timescale 1ns/1ps
// Function
// - READ or WRITE may follow every cycle; device takes each READ, and each WRITE word while write_space is high.
// - Clock enable low suspends the device after one cycle.
// - Clock enable high resumes the device after one cycle.
// - Write mask applies to the data word of the same cycle.
// - Read outputs float two cycles after the mask is sampled high.
// - First write word arrives with the WRITE command, zero delay.
// - PRECHARGE ends read data after three or two cycles by latency.
// - First read word appears two or three clocks after READ.
module sdram_command_timing
	import sdram_timing_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Command pins.
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ROW_W-1:0] addr,
	input wire logic dqm,
	// Data pins, split into input, output and enable.
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	// Status.
	output logic clock_suspended,
	output logic write_space,
	// Array read port; data returns in the same cycle.
	output logic arr_rd_en,
	output logic [ARR_ADDR_W-1:0] arr_rd_addr,
	input wire logic [DQ_W-1:0] arr_rd_data,
	// Array write port, fed from the write buffer.
	output logic arr_wr_valid,
	output logic [ARR_ADDR_W-1:0] arr_wr_addr,
	output logic [DQ_W-1:0] arr_wr_data,
	input wire logic arr_wr_ready
);

	logic [3:0] cmd;
	logic cmd_ok;
	logic is_act;
	logic is_read;
	logic is_write;
	logic is_pre;
	logic is_bst;
	logic is_lmr;
	logic pre_hit;
	logic beat_cont;
	logic rd_beat;
	logic wr_beat;
	logic [BANK_W-1:0] beat_bank;
	logic [COL_W-1:0] beat_col;
	logic sel_valid;
	logic [DQ_W-1:0] sel_data;
	logic suspended_r;
	logic lat3_r;
	logic [2:0] bl_code_r;
	logic [ROW_W-1:0] open_row_r [BANKS];
	burst_state_type state_r;
	logic [BANK_W-1:0] bank_r;
	logic [COL_W-1:0] col_r;
	logic [BURST_W-1:0] left_r;
	logic rd_en_r;
	logic [ARR_ADDR_W-1:0] rd_addr_r;
	logic p1_valid_r;
	logic [DQ_W-1:0] p1_data_r;
	logic dqm_d1_r;
	logic out_valid_r;
	logic [DQ_W-1:0] dq_out_r;
	logic dq_oe_r;

	stream_if #(.WIDTH(WR_WORD_W)) push_if ();
	stream_if #(.WIDTH(WR_WORD_W)) pop_if ();

	// Beats per burst for a mode code; reserved codes give one beat.
	function automatic logic [BURST_W-1:0] burst_len(input logic [2:0] code);
		logic [BURST_W-1:0] len;
		len = BURST_ONE;
		if (code == BL_CODE_FULL) begin
			len = BURST_FULL;
		end else if (code <= 3'h3) begin
			len = BURST_ONE << code;
		end
		return len;
	endfunction

	// Command decode; nothing is taken while the clock is suspended.
	always_comb begin
		cmd = {cs_n, ras_n, cas_n, we_n};
		cmd_ok = !suspended_r;
		is_act = cmd_ok && (cmd == CMD_ACT);
		is_read = cmd_ok && (cmd == CMD_READ);
		is_write = cmd_ok && (cmd == CMD_WRITE);
		is_pre = cmd_ok && (cmd == CMD_PRE);
		is_bst = cmd_ok && (cmd == CMD_BST);
		is_lmr = cmd_ok && (cmd == CMD_LMR);
		pre_hit = is_pre && (addr[AP_BIT] || (ba == bank_r));
		beat_cont = cmd_ok && (state_r != BURST_IDLE) && !pre_hit &&
			!is_bst && !is_read && !is_write;
		// A new column command always wins over a running burst.
		beat_bank = (is_read || is_write) ? ba : bank_r;
		beat_col = (is_read || is_write) ? addr[COL_W-1:0] : col_r;
		rd_beat = is_read || (beat_cont && (state_r == BURST_READ));
		wr_beat = is_write || (beat_cont && (state_r == BURST_WRITE));
	end

	// Clock enable is seen one edge late, which gives the entry/exit latency.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			suspended_r <= 1'b0;
		end else begin
			suspended_r <= !cke;
		end
	end

	// Mode word; loads are only legal with every bank idle.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lat3_r <= 1'b0;
			bl_code_r <= BL_CODE_RESET;
		end else if (is_lmr) begin
			lat3_r <= (addr[RLS_MSB:RLS_LSB] == RLS_THREE);
			bl_code_r <= addr[BL_MSB:BL_LSB];
		end
	end

	// Open row per bank.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < BANKS; i++) begin
				open_row_r[i] <= '0;
			end
		end else if (is_act) begin
			open_row_r[ba] <= addr;
		end
	end

	// Burst sequencer: stops on burst stop or a precharge of its bank.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= BURST_IDLE;
			bank_r <= '0;
			col_r <= '0;
			left_r <= '0;
		end else if (is_read || is_write) begin
			bank_r <= ba;
			col_r <= addr[COL_W-1:0] + 8'h01;
			left_r <= burst_len(bl_code_r) - BURST_ONE;
			if (burst_len(bl_code_r) == BURST_ONE) begin
				state_r <= BURST_IDLE;
			end else begin
				state_r <= is_read ? BURST_READ : BURST_WRITE;
			end
		end else if (pre_hit || is_bst) begin
			state_r <= BURST_IDLE;
		end else if (beat_cont) begin
			col_r <= col_r + 8'h01;
			left_r <= left_r - BURST_ONE;
			if (left_r == BURST_ONE) begin
				state_r <= BURST_IDLE;
			end
		end
	end

	// Array reads are issued on the edge that takes the beat.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_en_r <= 1'b0;
			rd_addr_r <= '0;
		end else begin
			rd_en_r <= rd_beat;
			if (rd_beat) begin
				rd_addr_r <= {beat_bank, open_row_r[beat_bank], beat_col};
			end
		end
	end

	// Latency three adds one stage ahead of the output flop.
	always_comb begin
		sel_valid = lat3_r ? p1_valid_r : rd_en_r;
		sel_data = lat3_r ? p1_data_r : arr_rd_data;
	end

	// Read pipeline; the pins register so the word stands a full cycle.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p1_valid_r <= 1'b0;
			p1_data_r <= '0;
			dqm_d1_r <= 1'b0;
			out_valid_r <= 1'b0;
			dq_out_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			p1_valid_r <= rd_en_r;
			p1_data_r <= arr_rd_data;
			dqm_d1_r <= dqm;
			out_valid_r <= sel_valid;
			dq_out_r <= sel_data;
			dq_oe_r <= sel_valid && !dqm_d1_r;
		end
	end

	// Write words enter the buffer on the command edge itself; a masked
	// word is simply not stored. A word offered while the buffer is full
	// is lost, so the controller must watch write_space.
	assign push_if.valid = wr_beat && !dqm;
	assign push_if.data = {beat_bank, open_row_r[beat_bank], beat_col, dq_in};
	assign pop_if.ready = arr_wr_ready;

	stream_fifo #(.WIDTH(WR_WORD_W), .DEPTH(WR_FIFO_DEPTH)) wr_fifo (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.in_s(push_if),
		.out_s(pop_if)
	);

	// Outputs.
	assign dq_out = dq_out_r;
	assign dq_oe = dq_oe_r;
	assign clock_suspended = suspended_r;
	assign write_space = push_if.ready;
	assign arr_rd_en = rd_en_r;
	assign arr_rd_addr = rd_addr_r;
	assign arr_wr_valid = pop_if.valid;
	assign arr_wr_addr = pop_if.data[WR_WORD_W-1:DQ_W];
	assign arr_wr_data = pop_if.data[DQ_W-1:0];

	a_suspend_entry:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		!cke |=> clock_suspended ##1 !arr_rd_en)
		else $error("Clock suspend not entered one cycle after enable fell.");

	a_suspend_exit:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		cke |=> !clock_suspended)
		else $error("Clock not resumed one cycle after enable rose.");

	a_write_mask_now:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_write && dqm) |-> !push_if.valid)
		else $error("Masked write word was stored.");

	a_write_first_word:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_write && !dqm && write_space) |-> push_if.valid &&
		push_if.data[DQ_W-1:0] == dq_in ##1 !write_space || arr_wr_valid)
		else $error("First write word not taken with the command.");

	a_read_float_mask:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		dqm |-> ##2 !dq_oe)
		else $error("Outputs not floated two cycles after read mask.");

	a_read_latency_two:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_read && !lat3_r) |-> ##2 out_valid_r)
		else $error("Read word missing two cycles after READ.");

	a_read_latency_three:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_read && lat3_r) |-> ##3 out_valid_r)
		else $error("Read word missing three cycles after READ.");

	a_pre_float_three:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(pre_hit && lat3_r) |-> ##3 !dq_oe)
		else $error("Outputs not floated three cycles after PRECHARGE.");

	a_pre_float_two:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(pre_hit && !lat3_r) |-> ##2 !dq_oe)
		else $error("Outputs not floated two cycles after PRECHARGE.");

	a_column_each_cycle:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		is_read |=> arr_rd_en &&
		arr_rd_addr[COL_W-1:0] == $past(addr[COL_W-1:0]))
		else $error("Column command not accepted in its cycle.");

endmodule // sdram_command_timing

/* File: ctrl_model.sv */
`timescale 1ns/1ps
// Behavioural memory controller driving the command and data pins.
module ctrl_model (
	// Clock.
	input wire logic sys_clk,
	// Pins toward the device.
	output logic cke,
	output logic [3:0] cmd,
	output logic [1:0] ba,
	output logic [11:0] addr,
	output logic dqm,
	output logic [15:0] dq_in
);
	// Idle pins at time zero.
	initial begin
		cke = 1'b1;
		cmd = 4'hF;
		ba = 2'h0;
		addr = 12'h000;
		dqm = 1'b0;
		dq_in = 16'hFFFF;
	end
	// One command per call, set at a falling edge and held a full cycle.
	// Write data rides with the WRITE command itself.
	task automatic op(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic m, input logic [15:0] d);
		cmd = c;
		ba = b;
		addr = a;
		dqm = m;
		dq_in = d;
		@(negedge sys_clk);
	endtask
	// Command without data: mask low, released data shows its inverse.
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a);
		op(c, b, a, 1'b0, ~dq_in);
	endtask
	// Gaps between commands; released data shows its inverse.
	task automatic idle(input int n);
		repeat (n) op(4'hF, ba, addr, 1'b0, ~dq_in);
	endtask
	// Clock enable changes take a falling edge as well.
	task automatic set_cke(input logic v);
		cke = v;
		@(negedge sys_clk);
	endtask
endmodule // ctrl_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb
	import sdram_timing_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic arr_wr_ready = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, clock_suspended;
	logic write_space, arr_rd_en, arr_wr_valid;
	logic [3:0] cmd;
	logic [1:0] ba;
	logic [11:0] addr;
	logic [15:0] dq_in, dq_out, arr_wr_data, arr_rd_data;
	logic [ARR_ADDR_W-1:0] arr_rd_addr, arr_wr_addr;
	int bad_count = 0;
	int checks_done = 0;
	// Array stand-in: the word read depends on its low address bits only.
	assign arr_rd_data = arr_rd_addr[15:0] ^ 16'h5A5A;
	assign {cs_n, ras_n, cas_n, we_n} = cmd;
	// Clock of 4 ns period.
	initial begin
		forever #2 sys_clk = ~sys_clk; // Gaps count cycles
	end
	ctrl_model ctrl_u (.sys_clk(sys_clk), .cke(cke), .cmd(cmd), .ba(ba),
		.addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdram_command_timing dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .clock_suspended(clock_suspended),
		.write_space(write_space), .arr_rd_en(arr_rd_en),
		.arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data),
		.arr_wr_valid(arr_wr_valid), .arr_wr_addr(arr_wr_addr),
		.arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready));
	// Compare one value and count it.
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run.
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Open a row, then two reads on consecutive cycles.
	task automatic read_pair();
		ctrl_u.issue(CMD_ACT, 2'h2, 12'h123);
		ctrl_u.idle(4);
		ctrl_u.issue(CMD_READ, 2'h2, 12'h010);
		ctrl_u.issue(CMD_READ, 2'h2, 12'h011);
		chk("rd_oe", 16'h1, {15'h0, dq_oe});
		chk("rd_d0", 16'h2310 ^ 16'h5A5A, dq_out);
		ctrl_u.idle(1);
		chk("rd_d1", 16'h2311 ^ 16'h5A5A, dq_out);
		ctrl_u.idle(1);
		chk("rd_end", 16'h0, {15'h0, dq_oe});
	endtask
	// A masked read must leave the data pins undriven.
	task automatic read_masked();
		ctrl_u.op(CMD_READ, 2'h2, 12'h020, 1'b1, 16'h0);
		ctrl_u.op(4'hF, 2'h2, 12'h020, 1'b1, 16'h0);
		chk("mask_oe", 16'h0, {15'h0, dq_oe});
		ctrl_u.idle(1);
	endtask
	// Clock enable low freezes the command decoder one edge later.
	task automatic suspend();
		ctrl_u.set_cke(1'b0);
		chk("susp_on", 16'h1, {15'h0, clock_suspended});
		ctrl_u.issue(CMD_READ, 2'h2, 12'h030);
		chk("susp_rd", 16'h0, {15'h0, arr_rd_en});
		ctrl_u.set_cke(1'b1);
		chk("susp_off", 16'h0, {15'h0, clock_suspended});
		ctrl_u.idle(2);
	endtask
	// Fill the write buffer with the array stalled, then drain it.
	task automatic write_fill();
		logic [15:0] q[$];
		int n;
		q = '{16'hC000, 16'hC002, 16'hC003, 16'hC004};
		n = 0;
		ctrl_u.issue(CMD_ACT, 2'h1, 12'h0AB);
		ctrl_u.idle(4);
		for (int c = 0; c < 6; c++) begin
			ctrl_u.op(CMD_WRITE, 2'h1, 12'(c), c == 1, 16'hC000 + 16'(c));
			if (c == 0) begin
				chk("wr_data", 16'hC000, arr_wr_data);
				chk("wr_addr", 16'hAB00, arr_wr_addr[15:0]);
			end
			ctrl_u.idle(1);
		end
		chk("wr_full", 16'h0, {15'h0, write_space});
		arr_wr_ready = 1'b1;
		while (q.size() > 0 && n < 20) begin
			if (arr_wr_valid === 1'b1) begin
				chk("wr_drain", q.pop_front(), arr_wr_data);
			end
			@(negedge sys_clk);
			n++;
		end
		if (q.size() > 0) begin
			bad_count++;
			$display("BAD drain expected empty seen %0d left", q.size());
			stop_test();
		end
		chk("wr_empty", 16'h0, {15'h0, arr_wr_valid});
		chk("wr_space", 16'h1, {15'h0, write_space});
		arr_wr_ready = 1'b0;
	endtask
	// Latency three, burst of eight, cut short by a precharge.
	task automatic read_cut();
		ctrl_u.issue(CMD_PRE, 2'h0, 12'h400);
		ctrl_u.idle(5);
		ctrl_u.issue(CMD_LMR, 2'h0, 12'h033);
		ctrl_u.idle(2);
		ctrl_u.issue(CMD_ACT, 2'h3, 12'h0CD);
		ctrl_u.idle(9);
		ctrl_u.issue(CMD_READ, 2'h3, 12'h0FE);
		ctrl_u.idle(1);
		ctrl_u.issue(CMD_PRE, 2'h3, 12'h000);
		chk("cut_d0", 16'hCDFE ^ 16'h5A5A, dq_out);
		ctrl_u.idle(1);
		chk("cut_d1", 16'hCDFF ^ 16'h5A5A, dq_out);
		ctrl_u.idle(1);
		chk("cut_oe", 16'h0, {15'h0, dq_oe});
	endtask
	// Write burst of eight cut by burst stop; only two words may land.
	// The array is stalled first so that a runaway burst stays visible.
	task automatic write_stop();
		ctrl_u.issue(CMD_ACT, 2'h0, 12'h0EF);
		ctrl_u.idle(4);
		ctrl_u.op(CMD_WRITE, 2'h0, 12'h010, 1'b0, 16'hA110);
		ctrl_u.op(4'hF, 2'h0, 12'h010, 1'b0, 16'hA111);
		ctrl_u.op(CMD_BST, 2'h0, 12'h010, 1'b0, 16'hA112);
		chk("bst_d0", 16'hA110, arr_wr_data);
		chk("bst_a0", 16'hEF10, arr_wr_addr[15:0]);
		arr_wr_ready = 1'b1;
		ctrl_u.idle(1);
		chk("bst_d1", 16'hA111, arr_wr_data);
		chk("bst_a1", 16'hEF11, arr_wr_addr[15:0]);
		ctrl_u.idle(1);
		chk("bst_end", 16'h0, {15'h0, arr_wr_valid});
		arr_wr_ready = 1'b0;
		ctrl_u.issue(CMD_PRE, 2'h0, 12'h000);
		ctrl_u.idle(1);
	endtask
	// A hang is cut short here and reported as a mismatch.
	initial begin
		#20000; // Far below the refresh interval
		bad_count++;
		$display("BAD run expected done seen timeout");
		stop_test();
	end
	// Reset for six cycles, then the scenarios in turn.
	initial begin
		repeat (6) @(posedge sys_clk); // Scaled power-on wait
		@(negedge sys_clk);
		resetn = 1'b1;
		chk("rst_space", 16'h1, {15'h0, write_space});
		chk("rst_oe", 16'h0, {15'h0, dq_oe});
		ctrl_u.idle(2);
		read_pair();
		read_masked();
		suspend();
		write_fill();
		read_cut();
		write_stop();
		stop_test();
	end
endmodule // tb
